//--- common/rps_cfg.svh
// constants for the rotating stage selector
`ifndef RPS_CFG_SVH
`define RPS_CFG_SVH

`define RPS_STAGES      16
`define RPS_GROUP       8
`define RPS_RING        32
`define RPS_COUNT_W     5
`define RPS_PAT_RESET   16'h0000
`define RPS_SYNC_RESET  3'h0

`endif

//--- common/rps_pkg.sv
// types for the rotating stage selector
package rps_pkg;

    // sequencer control states, one-hot
    typedef enum logic [1:0] {
        ST_LOAD = 2'h1,
        ST_RUN  = 2'h2
    } seq_state_t;

    // selections handed to the level summer and lamps
    typedef struct packed {
        logic [7:0]  sum_a;
        logic [7:0]  sum_b;
        logic [15:0] lamp;
    } stage_out_t;

endpackage

//--- design/pattern_rotating_stage_selector.sv
// rotating stage pattern register driving stage selections and lamps
`timescale 1ns/1ps
`default_nettype none
`include "rps_cfg.svh"

// Functional notes
// - sixteen bit stage pattern, one per stage
// - any number of bits active together
// - each step rise shifts toward higher stage, save one that meets a pattern load
// - last stage wraps back to first in the short ring; in long mode bit 31 wraps to first
// - select every active stage simultaneously
// - one lamp per stage, lit when active
// - stages 1-8, 9-16, plus combined output
// - pattern reload while running continues rotation
// - ring extends to thirty-two steps
// - single active bit acts as plain sequencer
module pattern_rotating_stage_selector (
    input  wire logic                      REF_CLK,
    input  wire logic                      RST,
    input  wire logic                      CLK_EN,
    input  wire logic                      STEP_CLK,
    input  wire logic [`RPS_STAGES-1:0]    PATTERN_SET,
    input  wire logic [`RPS_STAGES-1:0]    PATTERN_EXT,
    input  wire logic                      PATTERN_LOAD,
    input  wire logic                      LONG_MODE,
    output logic      [`RPS_STAGES-1:0]    LAMP,
    output logic      [`RPS_GROUP-1:0]     SUM_A_SEL,
    output logic      [`RPS_GROUP-1:0]     SUM_B_SEL,
    output logic      [`RPS_STAGES-1:0]    SUM_AB_SEL,
    output logic      [`RPS_COUNT_W-1:0]   ACTIVE_COUNT,
    output logic                           STEP_PULSE
);

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    logic [2:0]                 sync;
    logic [2:0]                 next_sync;
    logic                       step_level;
    logic                       next_step_level;
    logic                       step_rise;
    rps_pkg::seq_state_t        state;
    rps_pkg::seq_state_t        next_state;
    logic [`RPS_RING-1:0]       ring;
    logic [`RPS_RING-1:0]       next_ring;
    rps_pkg::stage_out_t        outs;
    rps_pkg::stage_out_t        next_outs;
    logic [`RPS_COUNT_W-1:0]    count;
    logic [`RPS_COUNT_W-1:0]    next_count;
    logic                       pulse;
    logic                       next_pulse;

    // count of active stages in a sixteen bit view
    function automatic logic [`RPS_COUNT_W-1:0] ones16(input logic [`RPS_STAGES-1:0] v);
        logic [`RPS_COUNT_W-1:0] n;
        n = '0;
        for (int i = 0; i < `RPS_STAGES; i++) begin
            n = n + {{(`RPS_COUNT_W-1){1'h0}}, v[i]};
        end
        return n;
    endfunction

    // rotate one place toward the higher stage; ring length 16 or 32
    function automatic logic [`RPS_RING-1:0] rotate(input logic [`RPS_RING-1:0] r,
                                                    input logic long_ring);
        logic [`RPS_RING-1:0] q;
        q = '0;
        if (long_ring) begin
            q = {r[`RPS_RING-2:0], r[`RPS_RING-1]};
        end else begin
            q = {r[`RPS_RING-1:`RPS_STAGES],
                 r[`RPS_STAGES-2:0], r[`RPS_STAGES-1]};
        end
        return q;
    endfunction

    // ---------------------------------------------------------------
    // step clock synchroniser and edge detect
    // ---------------------------------------------------------------
    // three stages; level accepted only when second and third agree
    always_comb begin
        next_sync       = {sync[1:0], STEP_CLK};
        next_step_level = step_level;
        if (sync[1] == sync[2]) begin
            next_step_level = sync[2];
        end
    end

    assign step_rise = next_step_level & ~step_level;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            sync       <= `RPS_SYNC_RESET;
            step_level <= 1'h0;
        end else if (CLK_EN) begin
            sync       <= next_sync;
            step_level <= next_step_level;
        end
    end

    // ---------------------------------------------------------------
    // pattern ring and control
    // ---------------------------------------------------------------
    // bit 0 is stage one; upper half only rotates in long mode
    always_comb begin
        next_state = state;
        next_ring  = ring;
        next_pulse = 1'h0;
        unique case (state)
            rps_pkg::ST_LOAD: begin
                next_ring  = {PATTERN_EXT, PATTERN_SET};
                next_state = rps_pkg::ST_RUN;
            end
            rps_pkg::ST_RUN: begin
                if (PATTERN_LOAD) begin
                    next_ring = {PATTERN_EXT, PATTERN_SET};
                end else if (step_rise) begin
                    next_ring  = rotate(ring, LONG_MODE);
                    next_pulse = 1'h1;
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state <= rps_pkg::ST_LOAD;
            ring  <= {`RPS_PAT_RESET, `RPS_PAT_RESET};
            pulse <= 1'h0;
        end else if (CLK_EN) begin
            state <= next_state;
            ring  <= next_ring;
            pulse <= next_pulse;
        end
    end

    // ---------------------------------------------------------------
    // selections, lamps and summer routing
    // ---------------------------------------------------------------
    // every active bit selects its stage, no one-hot limit
    always_comb begin
        next_outs.lamp  = next_ring[`RPS_STAGES-1:0];
        next_outs.sum_a = next_ring[`RPS_GROUP-1:0];
        next_outs.sum_b = next_ring[`RPS_STAGES-1:`RPS_GROUP];
        next_count      = ones16(next_ring[`RPS_STAGES-1:0]);
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            outs  <= '0;
            count <= '0;
        end else if (CLK_EN) begin
            outs  <= next_outs;
            count <= next_count;
        end
    end

    assign LAMP         = outs.lamp;
    assign SUM_A_SEL    = outs.sum_a;
    assign SUM_B_SEL    = outs.sum_b;
    assign SUM_AB_SEL   = {outs.sum_b, outs.sum_a};
    assign ACTIVE_COUNT = count;
    assign STEP_PULSE   = pulse;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    lamp_matches_ring_a: assert property (@(posedge REF_CLK) disable iff (RST)
        LAMP == ring[`RPS_STAGES-1:0])
        else $error("lamps differ from pattern");

    short_rotate_a: assert property (@(posedge REF_CLK) disable iff (RST)
        CLK_EN && state == rps_pkg::ST_RUN && step_rise && !PATTERN_LOAD && !LONG_MODE
        |=> LAMP == {$past(ring[`RPS_STAGES-2:0]), $past(ring[`RPS_STAGES-1])})
        else $error("short ring did not rotate by one");

    long_wrap_a: assert property (@(posedge REF_CLK) disable iff (RST)
        CLK_EN && state == rps_pkg::ST_RUN && step_rise && !PATTERN_LOAD && LONG_MODE
        |=> ring[0] == $past(ring[`RPS_RING-1]))
        else $error("long ring did not wrap");

    ring_hold_a: assert property (@(posedge REF_CLK) disable iff (RST)
        CLK_EN && state == rps_pkg::ST_RUN && !step_rise && !PATTERN_LOAD
        |=> $stable(ring))
        else $error("ring moved without step edge");

    reload_a: assert property (@(posedge REF_CLK) disable iff (RST)
        CLK_EN && state == rps_pkg::ST_RUN && PATTERN_LOAD
        |=> ring == {$past(PATTERN_EXT), $past(PATTERN_SET)})
        else $error("pattern reload missed");

    reset_load_a: assert property (@(posedge REF_CLK) disable iff (RST)
        CLK_EN && state == rps_pkg::ST_LOAD
        |=> state == rps_pkg::ST_RUN && ring == {$past(PATTERN_EXT), $past(PATTERN_SET)})
        else $error("pattern not loaded after reset");

    groups_split_a: assert property (@(posedge REF_CLK) disable iff (RST)
        SUM_AB_SEL == {SUM_B_SEL, SUM_A_SEL} && SUM_A_SEL == LAMP[`RPS_GROUP-1:0])
        else $error("group routing wrong");

    one_pulse_a: assert property (@(posedge REF_CLK) disable iff (RST)
        STEP_PULSE && CLK_EN |=> !STEP_PULSE)
        else $error("step pulse longer than one cycle");

    count_keeps_a: assert property (@(posedge REF_CLK) disable iff (RST)
        ACTIVE_COUNT == ones16(LAMP))
        else $error("active count wrong");

    rotate_keeps_count_a: assert property (@(posedge REF_CLK) disable iff (RST)
        CLK_EN && state == rps_pkg::ST_RUN && step_rise && !PATTERN_LOAD && !LONG_MODE
        |=> ACTIVE_COUNT == $past(ACTIVE_COUNT))
        else $error("bits lost in rotation");

    pulse_after_step_a: assert property (@(posedge REF_CLK) disable iff (RST)
        CLK_EN && state == rps_pkg::ST_RUN && step_rise && !PATTERN_LOAD
        |=> STEP_PULSE)
        else $error("no step pulse after shift");

    load_wins_a: assert property (@(posedge REF_CLK) disable iff (RST)
        CLK_EN && state == rps_pkg::ST_RUN && PATTERN_LOAD
        |=> !STEP_PULSE)
        else $error("step taken during pattern load");

    rise_agreed_a: assert property (@(posedge REF_CLK) disable iff (RST)
        step_rise |-> sync[1] && sync[2] && !step_level)
        else $error("step edge without agreeing flops");

endmodule
`default_nettype wire

//--- bench/rps_level_summer.sv
// level summer model fed by the stage selections
`timescale 1ns/1ps
`default_nettype none
module rps_level_summer (
    input  wire rps_pkg::stage_out_t sel,
    output logic [7:0]               level_a,
    output logic [7:0]               level_b,
    output logic [7:0]               level_total
);
    // stage n is programmed to level n, selected stages add up
    always_comb begin
        level_a = 8'h00;
        level_b = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (sel.sum_a[i]) level_a = level_a + 8'(i + 1);
            if (sel.sum_b[i]) level_b = level_b + 8'(i + 9);
        end
        level_total = level_a + level_b;
    end
endmodule
`default_nettype wire

//--- bench/pattern_rotating_stage_selector_tb_top.sv
// testbench for the rotating stage selector
`timescale 1ns/1ps
`default_nettype none
`include "rps_cfg.svh"
module pattern_rotating_stage_selector_tb_top;
    logic                REF_CLK = 1'h0;
    logic                RST = 1'h1;
    logic                CLK_EN = 1'h1;
    logic                STEP_CLK = 1'h0;
    logic                PATTERN_LOAD = 1'h0;
    logic                LONG_MODE = 1'h0;
    logic [15:0]         PATTERN_SET = 16'h0421;
    logic [15:0]         PATTERN_EXT = 16'h0000;
    logic [15:0]         LAMP, SUM_AB_SEL;
    logic [7:0]          SUM_A_SEL, SUM_B_SEL, level_a, level_b, level_total;
    logic [4:0]          ACTIVE_COUNT;
    logic                STEP_PULSE;
    logic [31:0]         ring = 32'h0000_0421;
    int                  bad_count = 0;
    int                  check_count = 0;
    rps_pkg::stage_out_t sel;

    assign sel = {SUM_A_SEL, SUM_B_SEL, LAMP};
    always #25 REF_CLK = ~REF_CLK;

    pattern_rotating_stage_selector i_pattern_rotating_stage_selector (
        .REF_CLK(REF_CLK), .RST(RST), .CLK_EN(CLK_EN), .STEP_CLK(STEP_CLK),
        .PATTERN_SET(PATTERN_SET), .PATTERN_EXT(PATTERN_EXT),
        .PATTERN_LOAD(PATTERN_LOAD), .LONG_MODE(LONG_MODE), .LAMP(LAMP),
        .SUM_A_SEL(SUM_A_SEL), .SUM_B_SEL(SUM_B_SEL), .SUM_AB_SEL(SUM_AB_SEL),
        .ACTIVE_COUNT(ACTIVE_COUNT), .STEP_PULSE(STEP_PULSE));
    rps_level_summer i_rps_level_summer (.sel(sel), .level_a(level_a),
        .level_b(level_b), .level_total(level_total));

    // compare one value and count it
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // all selection outputs against the ring model
    task automatic cmp_all();
        logic [7:0] et;
        logic [4:0] n;
        et = 8'h00;
        n = 5'h00;
        for (int i = 0; i < 8; i++) begin
            if (ring[i]) et = et + 8'(i + 1);
            if (ring[i + 8]) et = et + 8'(i + 9);
        end
        for (int i = 0; i < 16; i++) n = n + 5'(ring[i]);
        check("LAMP", 32'(LAMP), 32'(ring[15:0]));
        check("SUM_A_SEL", 32'(SUM_A_SEL), 32'(ring[7:0]));
        check("SUM_B_SEL", 32'(SUM_B_SEL), 32'(ring[15:8]));
        check("SUM_AB_SEL", 32'(SUM_AB_SEL), 32'(ring[15:0]));
        check("ACTIVE_COUNT", 32'(ACTIVE_COUNT), 32'(n));
        check("level_total", 32'(level_total), 32'(et));
    endtask

    // one step clock rise, held high until the pulse, then low
    task automatic step();
        int k;
        @(negedge REF_CLK) STEP_CLK = 1'b1;
        k = 0;
        while (STEP_PULSE !== 1'b1 && k < 8) begin
            @(negedge REF_CLK);
            k++;
        end
        check("STEP_PULSE", 32'(STEP_PULSE), 32'h1);
        STEP_CLK = 1'b0;
        if (LONG_MODE) ring = {ring[30:0], ring[31]};
        else ring = {ring[31:16], ring[14:0], ring[15]};
        cmp_all();
        @(negedge REF_CLK) check("STEP_PULSE", 32'(STEP_PULSE), 32'h0);
        repeat (3) @(negedge REF_CLK);
    endtask

    // load a new ring, pattern shows one cycle later
    task automatic load(input logic [15:0] ext, input logic [15:0] pat);
        @(negedge REF_CLK);
        PATTERN_EXT = ext;
        PATTERN_SET = pat;
        PATTERN_LOAD = 1'b1;
        @(negedge REF_CLK) PATTERN_LOAD = 1'b0;
        ring = {ext, pat};
        cmp_all();
    endtask

    // step clock toggles while frozen: nothing moves
    task automatic t_freeze();
        @(negedge REF_CLK) CLK_EN = 1'b0;
        STEP_CLK = 1'b1;
        repeat (4) @(negedge REF_CLK);
        STEP_CLK = 1'b0;
        repeat (4) @(negedge REF_CLK);
        CLK_EN = 1'b1;
        repeat (4) @(negedge REF_CLK);
        cmp_all();
    endtask

    // load and step edge in one cycle: load wins, rotation goes on from it
    task automatic t_collide();
        @(negedge REF_CLK) STEP_CLK = 1'h1;
        repeat (3) @(negedge REF_CLK);
        PATTERN_SET = 16'h0081;
        PATTERN_LOAD = 1'h1;
        @(negedge REF_CLK) PATTERN_LOAD = 1'h0;
        ring = {PATTERN_EXT, 16'h0081};
        cmp_all();
        check("STEP_PULSE", 32'(STEP_PULSE), 32'h0);
        STEP_CLK = 1'h0;
        repeat (4) @(negedge REF_CLK);
        step();
    endtask

    // reset in mid-run clears outputs, then the pattern inputs load again
    task automatic t_reset();
        @(negedge REF_CLK) RST = 1'h1;
        PATTERN_SET = 16'h1248;
        @(negedge REF_CLK) check("LAMP", 32'(LAMP), 32'h0);
        check("ACTIVE_COUNT", 32'(ACTIVE_COUNT), 32'h0);
        RST = 1'h0;
        ring = {PATTERN_EXT, 16'h1248};
        @(negedge REF_CLK) cmp_all();
        step();
    endtask

    // outputs clear in reset, first edge after release loads the pattern
    task automatic t_start();
        repeat (5) @(negedge REF_CLK);
        check("LAMP", 32'(LAMP), 32'h0);
        RST = 1'h0;
        @(negedge REF_CLK) cmp_all();
        step();
    endtask

    // one active bit walks all sixteen stages and wraps
    task automatic t_single();
        load(16'h0000, 16'h0001);
        repeat (17) step();
    endtask

    // several active bits move together, then a live reload
    task automatic t_multi();
        load(16'h0000, 16'h8305);
        repeat (9) step();
        load(16'h0000, 16'hF00F);
        step();
    endtask

    // upper ring half joins the rotation in long mode
    task automatic t_long();
        @(negedge REF_CLK) LONG_MODE = 1'h1;
        load(16'h8001, 16'h8000);
        repeat (33) step();
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // watchdog well beyond the expected run
    initial begin
        repeat (5000) @(posedge REF_CLK);
        bad_count++;
        finish_test();
    end

    // reset load, single bit, multi bit, collision, freeze, reset, long ring
    initial begin
        t_start();
        t_single();
        t_multi();
        t_collide();
        t_freeze();
        t_reset();
        t_long();
        finish_test();
    end
endmodule
`default_nettype wire
